//--- logic/ppc_cfg.svh
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// Register addresses (8-bit address space)
`define PPC_ADDR_PORT      8'h06
`define PPC_ADDR_IRQCTL    8'h0b
`define PPC_ADDR_OPTION    8'h81
`define PPC_ADDR_DIR       8'h86
`define PPC_ADDR_ISTAT     8'h90
`define PPC_ADDR_IMASK     8'h91

// Reset values
`define PPC_RST_OPTION     8'hff
`define PPC_RST_DIR        8'hff
`define PPC_RST_IRQCTL     8'h00
`define PPC_RST_LATCH      8'h00
`define PPC_RST_ISTAT      2'h0
`define PPC_RST_IMASK      2'h0

// Field positions
`define PPC_OPT_PULLUP_N   7
`define PPC_IC_GIE         7
`define PPC_IC_PCE         3
`define PPC_IC_PCF         0
`define PPC_IST_CHANGE     0
`define PPC_IST_WAKE       1

// Upper pin range that takes part in change detection
`define PPC_CHG_LO         4
`define PPC_CHG_HI         7

`endif

//--- logic/ppc_pkg.sv
package ppc_pkg;
  typedef logic [7:0] ppc_byte_t;
  typedef logic [1:0] ppc_evt_t;
endpackage : ppc_pkg

//--- logic/ppc_port.sv
// How it works
// R1 - Direction one puts pin driver in high-Z
// R2 - Direction zero drives pin from latch
// R3 - Port read gives pins, write sets latch
// R4 - Port write merges sampled pins into latch
// R5 - Clearing option bit 7 enables pull-ups
// R6 - Output pins never get pull-up
// R7 - Pull-ups off after power-on reset
// R8 - Only upper input pins compared
// R9 - Mismatch versus snapshot sets change flag
// R10 - Pin change wakes device from sleep
// R11 - Any port access refreshes snapshot
// R12 - Persisting mismatch keeps setting flag
// R13 - Change during port read may be missed
// R14 - Software should avoid polling with change irq
// R15 - Flag sets regardless of enables
// R16 - Global enable gates core_irq_o (irq_o is not gated), resets clear
// R17 - Request needs flag, enable and global
// R18 - Pins synchronised before any use
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module ppc_port
  import ppc_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire ppc_byte_t wdata_i,
  input  wire logic      wr_i,
  input  wire logic      rd_i,
  output ppc_byte_t      rdata_o,
  input  wire ppc_byte_t pin_i,
  output ppc_byte_t      pin_o,
  output ppc_byte_t      pin_oe_o,
  output ppc_byte_t      pullup_en_o,
  input  wire logic      sleep_i,
  output logic           wake_o,
  output logic           core_irq_o,
  output logic           irq_o
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  ppc_byte_t pin_s;

  ppc_sync u_sync (                                          // [R18]
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (pin_i),
    .sync_o     (pin_s)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_port;
  logic rd_port;
  logic wr_dir;
  logic wr_opt;
  logic wr_ic;
  logic wr_ist;
  logic wr_imk;

  assign wr_port = wr_i && (addr_i == `PPC_ADDR_PORT);
  assign rd_port = rd_i && (addr_i == `PPC_ADDR_PORT);
  assign wr_dir  = wr_i && (addr_i == `PPC_ADDR_DIR);
  assign wr_opt  = wr_i && (addr_i == `PPC_ADDR_OPTION);
  assign wr_ic   = wr_i && (addr_i == `PPC_ADDR_IRQCTL);
  assign wr_ist  = wr_i && (addr_i == `PPC_ADDR_ISTAT);
  assign wr_imk  = wr_i && (addr_i == `PPC_ADDR_IMASK);

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  ppc_byte_t latch_r, latch_nxt;
  ppc_byte_t dir_r, dir_nxt;
  ppc_byte_t opt_r, opt_nxt;
  ppc_byte_t snap_r, snap_nxt;
  ppc_byte_t ic_r, ic_nxt;
  ppc_evt_t  ist_r, ist_nxt;
  ppc_evt_t  imk_r, imk_nxt;
  ppc_byte_t rdata_r, rdata_nxt;
  ppc_evt_t  evt;
  logic      wake;
  logic [3:0] chg_bits;
  logic       mismatch;

  genvar gi;
  generate
    for (gi = `PPC_CHG_LO; gi <= `PPC_CHG_HI; gi++) begin : g_chg
      // Input pins only; outputs drop out of the comparison
      assign chg_bits[gi-`PPC_CHG_LO] =
        dir_r[gi] && (pin_s[gi] != snap_r[gi]);              // [R8] [R9]
    end
  endgenerate

  // Access cycle masks the compare, so a change landing here is lost
  assign mismatch = (|chg_bits) && !(rd_port || wr_port);    // [R13]

  // ----------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------
  assign wake = mismatch && sleep_i;                         // [R10]
  assign evt  = {wake, mismatch};

  always_comb begin
    latch_nxt = latch_r;
    dir_nxt   = dir_r;
    opt_nxt   = opt_r;
    snap_nxt  = snap_r;
    ic_nxt    = ic_r;
    ist_nxt   = ist_r;
    imk_nxt   = imk_r;
    if (wr_port) begin
      // Sampled pins on inputs, written data on outputs
      latch_nxt = (wdata_i & ~dir_r) | (pin_s & dir_r);      // [R3] [R4]
      snap_nxt  = pin_s;                                     // [R11]
    end
    if (rd_port) begin
      snap_nxt = pin_s;                                      // [R11]
    end
    if (wr_dir) begin
      dir_nxt = wdata_i;
    end
    if (wr_opt) begin
      opt_nxt = wdata_i;
    end
    if (wr_ic) begin
      ic_nxt = wdata_i;
    end
    // Hardware set wins over software clear
    if (mismatch) begin
      ic_nxt[`PPC_IC_PCF] = 1'b1;                            // [R12] [R15]
    end
    if (wr_imk) begin
      imk_nxt = wdata_i[1:0];
    end
    if (wr_ist) begin
      ist_nxt = ist_r & ~wdata_i[1:0];
    end
    ist_nxt = ist_nxt | evt;
  end

  always_comb begin
    unique case (addr_i)
      `PPC_ADDR_PORT:   rdata_nxt = pin_s;                   // [R3]
      `PPC_ADDR_DIR:    rdata_nxt = dir_r;
      `PPC_ADDR_OPTION: rdata_nxt = opt_r;
      `PPC_ADDR_IRQCTL: rdata_nxt = ic_r;
      `PPC_ADDR_ISTAT:  rdata_nxt = {6'h00, ist_r};
      `PPC_ADDR_IMASK:  rdata_nxt = {6'h00, imk_r};
      default:          rdata_nxt = 8'h00;
    endcase
    if (!rd_i) begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      latch_r <= `PPC_RST_LATCH;
      dir_r   <= `PPC_RST_DIR;
      opt_r   <= `PPC_RST_OPTION;                            // [R7]
      snap_r  <= 8'h00;
      ic_r    <= `PPC_RST_IRQCTL;                            // [R16]
      ist_r   <= `PPC_RST_ISTAT;
      imk_r   <= `PPC_RST_IMASK;
      rdata_r <= 8'h00;
    end else begin
      latch_r <= latch_nxt;
      dir_r   <= dir_nxt;
      opt_r   <= opt_nxt;
      snap_r  <= snap_nxt;
      ic_r    <= ic_nxt;
      ist_r   <= ist_nxt;
      imk_r   <= imk_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and outputs
  // ----------------------------------------------------------------
  assign pin_o       = latch_r;                              // [R2]
  assign pin_oe_o    = ~dir_r;                               // [R1]
  assign pullup_en_o = dir_r &
    {8{~opt_r[`PPC_OPT_PULLUP_N]}};                          // [R5] [R6]
  assign rdata_o     = rdata_r;
  assign wake_o      = ist_r[`PPC_IST_WAKE];
  assign core_irq_o  = ic_r[`PPC_IC_GIE] && ic_r[`PPC_IC_PCE] &&
                       ic_r[`PPC_IC_PCF];                    // [R16] [R17]
  assign irq_o       = |(ist_r & imk_r);

endmodule : ppc_port

//--- logic/ppc_sync.sv
`timescale 1ns/1ns
module ppc_sync
  import ppc_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      rst_n_i,
  input  wire ppc_byte_t async_i,
  output ppc_byte_t      sync_o
);

  ppc_byte_t meta_r;
  ppc_byte_t meta_nxt;
  ppc_byte_t sync_r;
  ppc_byte_t sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule : ppc_sync

//--- test/port_pin_change_irq_bench.sv
`timescale 1ns/1ns
module port_pin_change_irq_bench
  import ppc_pkg::*;
;
  logic      clk = 0, rst_n = 0, wr = 0, rd = 0, sleep = 0;
  logic      wake, cirq, irq;
  ppc_byte_t addr = 0, wdata = 0, key = 0, rdata, pin, pin_o, oe, pu;
  int        error_cnt = 0, checks_done = 0;
  always #10 clk = ~clk;
  ppc_port ppc_port_inst (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_i(pin),
    .pin_o(pin_o), .pin_oe_o(oe), .pullup_en_o(pu), .sleep_i(sleep),
    .wake_o(wake), .core_irq_o(cirq), .irq_o(irq));
  ppc_keypad ppc_keypad_inst (.core_clk_i(clk), .pin_o(pin_o),
    .pin_oe_o(oe), .pullup_en_o(pu), .key_i(key), .pad_o(pin));
  // ---------------------------------------------
  // Bus tasks
  // ---------------------------------------------
  task automatic chk(input ppc_byte_t seen, input ppc_byte_t exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr8(input ppc_byte_t a, input ppc_byte_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr8
  task automatic rd8(input ppc_byte_t a, input ppc_byte_t exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd8
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk(oe, 8'h00);
    chk(pu, 8'h00);
    rd8(8'h81, 8'hff);
    rd8(8'h20, 8'h00);
    $display("reset test done");
    wr8(8'h81, 8'h7f);
    wr8(8'h86, 8'hf0);
    chk(oe, 8'h0f);
    chk(pu, 8'hf0);
    cyc(3);
    wr8(8'h06, 8'ha5);
    chk(pin_o, 8'hf5);
    cyc(3);
    rd8(8'h06, 8'hf5);
    wr8(8'h0b, 8'h00);
    rd8(8'h0b, 8'h00);
    $display("port test done");
    wr8(8'h91, 8'h01);
    wr8(8'h0b, 8'h88);
    key <= 8'h20;
    cyc(5);
    chk({6'h0, cirq, irq}, 8'h03);
    wr8(8'h0b, 8'h88);
    rd8(8'h0b, 8'h89);
    rd8(8'h06, 8'hd5);
    wr8(8'h0b, 8'h88);
    rd8(8'h0b, 8'h88);
    wr8(8'h90, 8'h01);
    wr8(8'h0b, 8'h08);
    key <= 8'h00;
    cyc(5);
    chk({6'h0, cirq, irq}, 8'h01);
    rd8(8'h0b, 8'h09);
    $display("change test done");
    rd8(8'h06, 8'hf5);
    chk({7'h0, wake}, 8'h00);
    sleep <= 1'b1;
    key   <= 8'h80;
    cyc(5);
    chk({7'h0, wake}, 8'h01);
    sleep <= 1'b0;
    rd8(8'h06, 8'h75);
    wr8(8'h0b, 8'h08);
    wr8(8'h86, 8'h70);
    chk(pu, 8'h70);
    cyc(5);
    rd8(8'h0b, 8'h08);
    $display("wake test done");
    conclude();
  end
endmodule : port_pin_change_irq_bench

//--- test/ppc_keypad.sv
`timescale 1ns/1ns
module ppc_keypad
  import ppc_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire ppc_byte_t pin_o,
  input  wire ppc_byte_t pin_oe_o,
  input  wire ppc_byte_t pullup_en_o,
  input  wire ppc_byte_t key_i,
  output ppc_byte_t      pad_o
);
  // ---------------------------------------------
  // Pad level: driver, pressed key, pull-up, else noise
  // ---------------------------------------------
  ppc_byte_t flt_r = 8'h55;
  always @(posedge core_clk_i) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = pin_oe_o[i] ? pin_o[i] : key_i[i] ? 1'b0 :
                 pullup_en_o[i] ? 1'b1 : flt_r[i];
    end
  end
endmodule : ppc_keypad

//--- test/ppc_port_sva.sv
`timescale 1ns/1ns
module ppc_port_sva
  import ppc_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr_i,
  input wire ppc_byte_t  wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire ppc_byte_t  rdata_o,
  input wire ppc_byte_t  pin_i,
  input wire ppc_byte_t  pin_o,
  input wire ppc_byte_t  pin_oe_o,
  input wire ppc_byte_t  pullup_en_o,
  input wire logic       sleep_i,
  input wire logic       wake_o,
  input wire logic       core_irq_o,
  input wire logic       irq_o
);
  // ---------------------------------------------
  // Port checks
  // ---------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence pins_quiet_s;
    (rst_n_i && $stable(pin_i))[*4];
  endsequence
  a_oe_dir: assert property (
    wr_i && addr_i == 8'h86 |=> pin_oe_o == ~$past(wdata_i))
    else $error("direction not applied");
  a_out_no_pu: assert property (
    (pullup_en_o & pin_oe_o) == 8'h00) else $error("pull-up on output");
  a_pu_reset: assert property (
    $rose(rst_n_i) |-> pullup_en_o == 8'h00 && pin_oe_o == 8'h00)
    else $error("reset state wrong");
  a_pu_opt: assert property (
    wr_i && addr_i == 8'h81 |=> pullup_en_o ==
    (($past(wdata_i) >= 8'h80) ? 8'h00 : ~pin_oe_o)) else $error("pull-up");
  a_rd_pins: assert property (
    pins_quiet_s ##0 rd_i && addr_i == 8'h06 |=> rdata_o == $past(pin_i))
    else $error("port read wrong");
  a_port_rmw: assert property (
    pins_quiet_s ##0 wr_i && addr_i == 8'h06 |=> pin_o ==
    (($past(wdata_i) & pin_oe_o) | ($past(pin_i) & ~pin_oe_o)))
    else $error("port latch wrong");
  a_gie_off: assert property (
    wr_i && addr_i == 8'h0b && wdata_i < 8'h80 |=> !core_irq_o)
    else $error("request without global enable");
  a_rd_idle: assert property (
    !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
  a_wake_sleep: assert property (
    $rose(wake_o) |-> $past(sleep_i)) else $error("wake outside sleep");
  c_core_irq: cover property ($rose(core_irq_o));
  c_irq: cover property ($rose(irq_o));
  c_wake: cover property ($rose(wake_o));
endmodule : ppc_port_sva

bind ppc_port ppc_port_sva ppc_port_sva_inst (.*);
